// *** design/port3_pin_control.sv ***
// What this block does
// - A pin's open-drain select bit gates pin_oe only while its direction bit is 0 (output); in input mode it only forces pin_out to 0.
// - Bits 8 to 15 of the port latch are also reachable as bits 0 to 7 of an upper-byte alias.
// - Bits 8 to 15 of the direction register are also reachable as bits 0 to 7 of an upper-byte alias.
// - Bits 8 to 15 of the function control register are also reachable as bits 0 to 7 of an alias.
`timescale 1ns/10ps
`default_nettype none
module port3_pin_control #(
    parameter int unsigned W = port3_pkg::PORT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [port3_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [port3_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [port3_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Pins, split into level, drive and enable
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    // Alternate peripheral functions
    input wire logic [W-1:0] alt_out,
    output logic [W-1:0] alt_in
);
    localparam int unsigned H = port3_pkg::HALF_W;
    localparam int unsigned U = port3_pkg::UPPER_LSB;

    pin_ctrl_if #(.W(W)) pc ();

    logic [W-1:0] latch_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] fctl_q;
    logic [W-1:0] od_q;
    logic wait_q;
    logic [port3_pkg::DATA_W-1:0] rdata_q;

    // Bus decode
    wire logic req;
    wire logic wr_go;
    wire logic rd_go;
    wire logic lo_be;
    wire logic hi_be;
    assign req = read | write;
    // A write lands on the single edge where waitrequest is seen low
    assign wr_go = write & ~wait_q;
    // Read data are captured one cycle early so they stand at the acknowledge edge
    assign rd_go = read & wait_q;
    assign lo_be = byteenable[0];
    assign hi_be = byteenable[1];

    wire logic sel_latch;
    wire logic sel_latch_up;
    wire logic sel_dir;
    wire logic sel_dir_up;
    wire logic sel_fctl;
    wire logic sel_fctl_up;
    wire logic sel_od;
    wire logic sel_od_up;
    wire logic sel_level;
    assign sel_latch = (address == port3_pkg::OFF_LATCH);
    assign sel_latch_up = (address == port3_pkg::OFF_LATCH_UPPER);
    assign sel_dir = (address == port3_pkg::OFF_DIR);
    assign sel_dir_up = (address == port3_pkg::OFF_DIR_UPPER);
    assign sel_fctl = (address == port3_pkg::OFF_FCTL);
    assign sel_fctl_up = (address == port3_pkg::OFF_FCTL_UPPER);
    assign sel_od = (address == port3_pkg::OFF_OD);
    assign sel_od_up = (address == port3_pkg::OFF_OD_UPPER);
    assign sel_level = (address == port3_pkg::OFF_PIN_LEVEL);

    // Per-register byte write strobes: full word low lane, full word high lane, alias lane 0
    wire logic latch_wl;
    wire logic latch_wh;
    wire logic dir_wl;
    wire logic dir_wh;
    wire logic fctl_wl;
    wire logic fctl_wh;
    wire logic od_wl;
    wire logic od_wh;
    assign latch_wl = wr_go & sel_latch & lo_be;
    assign latch_wh = wr_go & ((sel_latch & hi_be) | (sel_latch_up & lo_be));
    assign dir_wl = wr_go & sel_dir & lo_be;
    assign dir_wh = wr_go & ((sel_dir & hi_be) | (sel_dir_up & lo_be));
    assign fctl_wl = wr_go & sel_fctl & lo_be;
    assign fctl_wh = wr_go & ((sel_fctl & hi_be) | (sel_fctl_up & lo_be));
    assign od_wl = wr_go & sel_od & lo_be;
    assign od_wh = wr_go & ((sel_od & hi_be) | (sel_od_up & lo_be));

    // High byte comes from lane 1 on the full word, lane 0 on the alias
    wire logic [H-1:0] lo_byte;
    wire logic [H-1:0] hi_byte_full;
    wire logic [H-1:0] up_byte;
    assign lo_byte = writedata[H-1:0];
    assign hi_byte_full = writedata[2*H-1:H];
    assign up_byte = (sel_latch_up | sel_dir_up | sel_fctl_up | sel_od_up) ?
        lo_byte : hi_byte_full;

    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= port3_pkg::RST_LATCH;
        end else begin
            if (latch_wl) begin
                latch_q[H-1:0] <= lo_byte;
            end
            if (latch_wh) begin
                latch_q[W-1:U] <= up_byte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= port3_pkg::RST_DIR;
        end else begin
            if (dir_wl) begin
                dir_q[H-1:0] <= lo_byte;
            end
            if (dir_wh) begin
                dir_q[W-1:U] <= up_byte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fctl_q <= port3_pkg::RST_FCTL;
        end else begin
            if (fctl_wl) begin
                fctl_q[H-1:0] <= lo_byte;
            end
            if (fctl_wh) begin
                fctl_q[W-1:U] <= up_byte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            od_q <= port3_pkg::RST_OD;
        end else begin
            if (od_wl) begin
                od_q[H-1:0] <= lo_byte;
            end
            if (od_wh) begin
                od_q[W-1:U] <= up_byte;
            end
        end
    end

    // Read mux; unmapped words read as zero and ignore writes
    wire logic [W-1:0] rd_word;
    wire logic [port3_pkg::DATA_W-1:0] rd_full;
    assign rd_word =
        sel_latch ? latch_q :
        sel_latch_up ? {{H{1'h0}}, latch_q[W-1:U]} :
        sel_dir ? dir_q :
        sel_dir_up ? {{H{1'h0}}, dir_q[W-1:U]} :
        sel_fctl ? fctl_q :
        sel_fctl_up ? {{H{1'h0}}, fctl_q[W-1:U]} :
        sel_od ? od_q :
        sel_od_up ? {{H{1'h0}}, od_q[W-1:U]} :
        sel_level ? pc.pin_level :
        {W{1'h0}};
    assign rd_full = {{(port3_pkg::DATA_W-W){1'h0}}, rd_word};

    // Every access takes exactly one wait cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 1'h1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (rd_go) begin
            rdata_q <= rd_full;
        end
    end

    // Pin cells
    assign pc.latch = latch_q;
    assign pc.dir = dir_q;
    assign pc.fctl = fctl_q;
    assign pc.od = od_q;
    assign pc.alt_out = alt_out;

    pin_cells #(
        .W(W),
        .STAGES(port3_pkg::SYNC_STAGES)
    ) u_cells (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pin_in),
        .pc(pc)
    );

    // Outputs, each straight from a flip-flop
    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign pin_out = pc.pin_out;
    assign pin_oe = pc.pin_oe;
    // Peripherals see the filtered pin level whatever the pin mode
    assign alt_in = pc.pin_level;
endmodule // port3_pin_control
`default_nettype wire

// *** inc/port3_pkg.sv ***
`default_nettype none
package port3_pkg;
    // Port width and upper-half geometry
    localparam int unsigned PORT_W = 16;
    localparam int unsigned HALF_W = 8;
    localparam int unsigned UPPER_LSB = 8;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SYNC_STAGES = 3;

    // Byte addresses of the register words
    localparam logic [5:0] OFF_LATCH = 6'h00;
    localparam logic [5:0] OFF_LATCH_UPPER = 6'h04;
    localparam logic [5:0] OFF_DIR = 6'h08;
    localparam logic [5:0] OFF_DIR_UPPER = 6'h0c;
    localparam logic [5:0] OFF_FCTL = 6'h10;
    localparam logic [5:0] OFF_FCTL_UPPER = 6'h14;
    localparam logic [5:0] OFF_OD = 6'h18;
    localparam logic [5:0] OFF_OD_UPPER = 6'h1c;
    localparam logic [5:0] OFF_PIN_LEVEL = 6'h20;

    // Reset values: pins come up as plain port inputs
    localparam logic [15:0] RST_LATCH = 16'h0000;
    localparam logic [15:0] RST_DIR = 16'hffff;
    localparam logic [15:0] RST_FCTL = 16'h0000;
    localparam logic [15:0] RST_OD = 16'h0000;

    // Direction encoding
    localparam logic DIR_OUTPUT = 1'h0;
    localparam logic DIR_INPUT = 1'h1;
    // Function control encoding
    localparam logic FCTL_PORT = 1'h0;
    localparam logic FCTL_ALT = 1'h1;
endpackage
`default_nettype wire

// *** inc/pin_ctrl_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface pin_ctrl_if #(
    parameter int unsigned W = 16
);
    // Register settings toward the pin cells
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] fctl;
    logic [W-1:0] od;
    logic [W-1:0] alt_out;
    // Pin state back from the pin cells
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    logic [W-1:0] pin_level;

    modport ctrl (
        output latch,
        output dir,
        output fctl,
        output od,
        output alt_out,
        input pin_out,
        input pin_oe,
        input pin_level
    );
    modport drv (
        input latch,
        input dir,
        input fctl,
        input od,
        input alt_out,
        output pin_out,
        output pin_oe,
        output pin_level
    );
endinterface
`default_nettype wire

// *** design/pin_cells.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_cells #(
    parameter int unsigned W = 16,
    parameter int unsigned STAGES = port3_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin levels from outside
    input wire logic [W-1:0] pin_in,
    // Settings in, pin drive and level out
    pin_ctrl_if.drv pc
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            wire logic value;
            wire logic is_input;
            wire logic drive_oe;
            wire logic drive_val;
            logic [STAGES-1:0] sync_q;
            logic out_q;
            logic oe_q;
            logic level_q;

            assign value = (pc.fctl[i] == port3_pkg::FCTL_ALT) ? pc.alt_out[i] : pc.latch[i];
            assign is_input = (pc.dir[i] == port3_pkg::DIR_INPUT);
            // Open drain only sets the enable in output mode, but zeroes the driven value in either mode; pulls low, releases for a one
            assign drive_oe = is_input ? 1'h0 : (pc.od[i] ? ~value : 1'h1);
            assign drive_val = pc.od[i] ? 1'h0 : value;

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    out_q <= 1'h0;
                    oe_q <= 1'h0;
                end else begin
                    out_q <= drive_val;
                    oe_q <= drive_oe;
                end
            end

            // First stage feeds only the second; a change counts once stages two and three agree
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    sync_q <= '0;
                    level_q <= 1'h0;
                end else begin
                    sync_q <= {sync_q[STAGES-2:0], pin_in[i]};
                    if (sync_q[STAGES-1] == sync_q[STAGES-2]) begin
                        level_q <= sync_q[STAGES-1];
                    end
                end
            end

            assign pc.pin_out[i] = out_q;
            assign pc.pin_oe[i] = oe_q;
            assign pc.pin_level[i] = level_q;
        end
    endgenerate
endmodule // pin_cells
`default_nettype wire

// *** tb/port3_pin_control_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module port3_pin_control_checker #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic [port3_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [port3_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest,
    // Pins
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_rd_ack;
        read && !waitrequest;
    endsequence
    chk_one_wait: assert property (s_req |=> !waitrequest)
        else $error("bus answer missing after one wait cycle");
    chk_ack_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("bus answer held longer than one cycle");
    chk_idle_quiet: assert property (!read && !write |=> waitrequest)
        else $error("bus answer without request");
    chk_upper_zero: assert property (s_rd_ack |-> readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    chk_latch_alias: assert property (s_rd_ack and address == 6'h04 |-> readdata[31:8] == 0)
        else $error("latch alias read wider than a byte");
    chk_dir_alias: assert property (s_rd_ack and address == 6'h0c |-> readdata[31:8] == 0)
        else $error("direction alias read wider than a byte");
    chk_fctl_alias: assert property (s_rd_ack and address == 6'h14 |-> readdata[31:8] == 0)
        else $error("function alias read wider than a byte");
    chk_input_quiet: assert property ($rose(rst_n) |-> pin_oe == 0 && pin_out == 0)
        else $error("pins driven while all are inputs");
endmodule // port3_pin_control_checker
bind port3_pin_control port3_pin_control_checker #(.W(W)) chk_i (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// *** tb/pin_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    // Our drive and the outside circuit
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] ext_val,
    // Peripheral outputs and the far side's own setup
    input wire logic [15:0] periph_val,
    input wire logic [1:0] func_sel_3,
    input wire logic [1:0] func_sel_4,
    input wire logic rx_mode,
    input wire logic [1:0] edge_en,
    input wire logic rx_en,
    input wire logic sck_mode,
    input wire logic trig_en,
    input wire logic trig_mode,
    input wire logic [3:0] clk_src,
    // Resolved pin level, alternate outputs and setup check
    output logic [15:0] pin_in,
    output logic [15:0] alt_out,
    output logic far_ok
);
    localparam logic [3:0] CLK_SRC_EXT = 4'hb;
    localparam logic [1:0] FSEL_ALT = 2'h3;
    wire logic rx_ok;
    wire logic sck_ok;
    // A released pin follows the outside circuit, never the last driven value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
    // Pins 3 and 4 give no defined output until both select bits are set
    always_comb begin
        alt_out = periph_val;
        if (func_sel_3 != FSEL_ALT) begin
            alt_out[3] = 1'hx;
        end
        if (func_sel_4 != FSEL_ALT) begin
            alt_out[4] = 1'hx;
        end
    end
    // Receive use needs both edge enables clear; interrupt use needs the receiver stopped
    assign rx_ok = rx_mode ? (edge_en == 2'h0) : !rx_en;
    // Serial clock use needs the trigger off or trig_mode set; trigger use needs another clock source
    assign sck_ok = sck_mode ? (!trig_en || trig_mode) : (clk_src != CLK_SRC_EXT);
    assign far_ok = rx_ok & sck_ok;
endmodule // pin_partner
`default_nettype wire

// *** tb/port3_pin_control_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module port3_pin_control_tb_top;
    logic clk, rst_n, read, write, waitrequest;
    logic [5:0] address;
    logic [31:0] writedata, readdata, q, r;
    logic [3:0] byteenable;
    logic [15:0] pin_in, pin_out, pin_oe, alt_out, alt_in, ext_val, v, oe, periph_val;
    logic [1:0] func_sel_3, func_sel_4, edge_en;
    logic rx_mode, rx_en, sck_mode, trig_en, trig_mode, far_ok;
    logic [3:0] clk_src;
    logic [15:0] m[4];
    int n_errors, checks, seed, k;
    port3_pin_control dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .alt_out(alt_out), .alt_in(alt_in));
    pin_partner far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .periph_val(periph_val), .func_sel_3(func_sel_3), .func_sel_4(func_sel_4),
        .rx_mode(rx_mode), .edge_en(edge_en), .rx_en(rx_en), .sck_mode(sck_mode),
        .trig_en(trig_en), .trig_mode(trig_mode), .clk_src(clk_src), .pin_in(pin_in),
        .alt_out(alt_out), .far_ok(far_ok));
    task automatic stop_test();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            n_errors++;
            stop_test();
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic [5:0] a);
        if (a == 6'h20) return {16'h0000, (oe & v) | (~oe & ext_val)};
        if (a[5]) return 32'h00000000;
        if (a[2]) return {24'h000000, m[a[4:3]][15:8]};
        return {16'h0000, m[a[4:3]]};
    endfunction
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
        // Upper lanes carry noise that the block must ignore
        bus(1'b1, a, {16'($random(seed)), d}, be);
        if (a[5]) return;
        // An alias write only ever lands on the upper byte
        if (a[2] && be[0]) m[a[4:3]][15:8] = d[7:0];
        if (!a[2] && be[0]) m[a[4:3]][7:0] = d[7:0];
        if (!a[2] && be[1]) m[a[4:3]][15:8] = d[15:8];
    endtask
    task automatic rd(input logic [5:0] a);
        bus(1'b0, a, 32'h00000000, 4'h0);
        chk(q, exp_rd(a));
    endtask
    task automatic model_reset();
        m[0] = port3_pkg::RST_LATCH;
        m[1] = port3_pkg::RST_DIR;
        m[2] = port3_pkg::RST_FCTL;
        m[3] = port3_pkg::RST_OD;
    endtask
    task automatic sweep();
        for (int i = 0; i < 10; i++) rd(6'(i * 4));
    endtask
    // Waits out pin update plus the input synchroniser and filter
    task automatic pins();
        repeat (8) @(posedge clk);
        v = (m[2] & periph_val) | (~m[2] & m[0]);
        oe = ~m[1] & (~m[3] | ~v);
        chk({16'h0000, pin_oe}, {16'h0000, oe});
        chk({16'h0000, pin_out & oe}, {16'h0000, v & oe});
        chk({16'h0000, alt_in}, {16'h0000, (oe & v) | (~oe & ext_val)});
        chk({31'h00000000, far_ok}, 32'h00000001);
        rd(6'h20);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        periph_val = 16'h0000;
        // Both select bits of pins 3 and 4 are set before any function bit
        func_sel_3 = 2'h3;
        func_sel_4 = 2'h3;
        rx_mode = 1'h1;
        edge_en = 2'h0;
        rx_en = 1'h1;
        sck_mode = 1'h1;
        trig_en = 1'h0;
        trig_mode = 1'h0;
        clk_src = 4'hb;
        r = 32'h00000000;
        ext_val = 16'h0000;
        v = 16'h0000;
        oe = 16'h0000;
        n_errors = 0;
        checks = 0;
        seed = 22;
        model_reset();
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        sweep();
        $display("test reset values done");
        for (k = 0; k < 40; k++) begin
            periph_val <= 16'($random(seed));
            r = $random(seed);
            rx_mode <= r[0];
            edge_en <= r[0] ? 2'h0 : r[2:1];
            rx_en <= r[0] & r[3];
            sck_mode <= r[4];
            trig_mode <= r[6];
            trig_en <= r[5] & (!r[4] | r[6]);
            clk_src <= r[4] ? 4'hb : ((r[10:7] == 4'hb) ? 4'ha : r[10:7]);
            ext_val <= 16'($random(seed));
            wr(6'($random(seed)) & 6'h3c, 16'($random(seed)), 4'($random(seed)));
            rd(6'($random(seed)) & 6'h1c);
            pins();
        end
        sweep();
        $display("test random access and pins done");
        wr(6'h04, 16'h0003, 4'h1);
        wr(6'h1c, 16'h0003, 4'h1);
        wr(6'h14, 16'h0003, 4'h1);
        wr(6'h0c, 16'h00fc, 4'h1);
        periph_val <= 16'h0100;
        pins();
        $display("test open drain alternate done");
        // A reset in mid-run must bring every register and pin back to rest
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        model_reset();
        pins();
        sweep();
        $display("test reset in mid-run done");
        stop_test();
    end
endmodule // port3_pin_control_tb_top
`default_nettype wire
